// *** pts_chan_mux.sv ***
// One channel's timebase router: picks one of three timers while in PWM mode.
// Assumes timer match pulses and counts are synchronous to clk.
`default_nettype none

module pts_chan_mux
  import pts_pkg::*;
#(
  parameter int TW = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pwm_mode,
  input wire logic [1:0] sel,
  input wire logic [PTS_NUM_TMR-1:0] tmr_match,
  input wire logic [PTS_NUM_TMR*TW-1:0] tmr_count,
  output logic period_restart,
  output logic [TW-1:0] duty_count
);

  logic restart_q;
  logic restart_d;
  logic [TW-1:0] count_q;
  logic [TW-1:0] count_d;
  logic sel_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Selection; reserved code routes nothing rather than a guessed timer
  assign sel_ok = pwm_mode && (sel != PTS_SEL_RSVD);
  assign restart_d = sel_ok ? tmr_match[sel] : 1'b0;
  assign count_d = sel_ok ? tmr_count[sel*TW +: TW] : '0;

  // Registered outputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      restart_q <= 1'b0;
      count_q <= '0;
    end
    else
    begin
      restart_q <= restart_d;
      count_q <= count_d;
    end
  end

  assign period_restart = restart_q;
  assign duty_count = count_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_t4_route;
    @(posedge clk) disable iff (!rst_b)
      (pwm_mode && sel == PTS_SEL_T4) |=> (period_restart == $past(tmr_match[1]))
        && (duty_count == $past(tmr_count[TW +: TW]));
  endproperty
  a_t4_route: assert property (p_t4_route) else $error("timer 4 not routed");

  property p_t2_route;
    @(posedge clk) disable iff (!rst_b)
      (pwm_mode && sel == PTS_SEL_T2 && tmr_match[0]) |=> period_restart;
  endproperty
  a_t2_route: assert property (p_t2_route) else $error("timer 2 match lost");

  property p_not_pwm;
    @(posedge clk) disable iff (!rst_b)
      (!pwm_mode || sel == PTS_SEL_RSVD) |=> (!period_restart && duty_count == '0);
  endproperty
  a_not_pwm: assert property (p_not_pwm) else $error("routed outside PWM");

endmodule // pts_chan_mux

`default_nettype wire

// *** pts_pkg.sv ***
// Package for the PWM timebase selection block: offsets, fields, codes, resets.
// Assumes a 32-bit Avalon-MM slave with byte addresses and 8-bit registers.
`default_nettype none

package pts_pkg;

  // Register byte offsets
  localparam logic [3:0] PTS_OFS_SEL_LO = 4'h0;
  localparam logic [3:0] PTS_OFS_SEL_HI = 4'h4;

  // Field layout
  localparam int PTS_SEL_W = 2;
  localparam int PTS_NUM_CHAN = 5;
  localparam int PTS_NUM_TMR = 3;
  localparam int PTS_LO_CHAN = 4;
  localparam int PTS_HI_LSB = 0;

  // Reset values
  localparam logic [7:0] PTS_RST_SEL_LO = 8'h00;
  localparam logic [1:0] PTS_RST_SEL_HI = 2'h0;

  // Selection codes
  localparam logic [1:0] PTS_SEL_T2 = 2'h0;
  localparam logic [1:0] PTS_SEL_T4 = 2'h1;
  localparam logic [1:0] PTS_SEL_T6 = 2'h2;
  localparam logic [1:0] PTS_SEL_RSVD = 2'h3;

endpackage

`default_nettype wire

// *** pts_timebase_select.sv ***
// Top of the PWM timebase selection block: Avalon-MM registers and five routers.
// Assumes a synchronous Avalon-MM master and timers in the clk domain.
`default_nettype none

// What this block does
// - Low register holds channels 1-4 selectors
// - Channel 2: 00 Timer 2, 01 Timer 4
// - High register bits 1-0 select channel 5
// - High register bits 7-2 read zero
// - All selectors reset to zero, Timer 2
module pts_timebase_select
  import pts_pkg::*;
#(
  parameter int TW = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PTS_NUM_CHAN-1:0] chan_pwm_mode,
  input wire logic [PTS_NUM_TMR-1:0] tmr_period_match,
  input wire logic [PTS_NUM_TMR*TW-1:0] tmr_count,
  output logic [PTS_NUM_CHAN-1:0] chan_period_restart,
  output logic [PTS_NUM_CHAN*TW-1:0] chan_duty_count
);

  if (TW < 1 || TW > 16)
  begin : g_bad_tw
    $error("TW must lie between 1 and 16");
  end

  logic [7:0] sel_lo_q;
  logic [7:0] sel_lo_d;
  logic [1:0] sel_hi_q;
  logic [1:0] sel_hi_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;
  logic hit_lo;
  logic hit_hi;
  logic wr_lo;
  logic wr_hi;
  logic [2*PTS_NUM_CHAN-1:0] all_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; every access waits one cycle so read data can be registered
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign ack_d = req && !ack_q;
  assign hit_lo = (avs_address == PTS_OFS_SEL_LO);
  assign hit_hi = (avs_address == PTS_OFS_SEL_HI);
  assign wr_lo = avs_write && ack_q && hit_lo && avs_byteenable[0];
  assign wr_hi = avs_write && ack_q && hit_hi && avs_byteenable[0];

  // Next register values; unimplemented high bits are never stored
  assign sel_lo_d = wr_lo ? avs_writedata[7:0] : sel_lo_q;
  assign sel_hi_d = wr_hi ? avs_writedata[PTS_HI_LSB +: PTS_SEL_W] : sel_hi_q;

  // Read mux; unmapped offsets read zero
  assign rdata_d = hit_lo ? {24'h000000, sel_lo_q} :
                   hit_hi ? {30'h00000000, sel_hi_q} : 32'h00000000;

  // Register storage
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sel_lo_q <= PTS_RST_SEL_LO;
      sel_hi_q <= PTS_RST_SEL_HI;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      sel_lo_q <= sel_lo_d;
      sel_hi_q <= sel_hi_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Channel routers; channel 1 sits in the low bits
  assign all_sel = {sel_hi_q, sel_lo_q};

  for (genvar c = 0; c < PTS_NUM_CHAN; c++)
  begin : g_chan
    pts_chan_mux #(.TW(TW)) u_mux (
      .clk(clk),
      .rst_b(rst_b),
      .pwm_mode(chan_pwm_mode[c]),
      .sel(all_sel[c*PTS_SEL_W +: PTS_SEL_W]),
      .tmr_match(tmr_period_match),
      .tmr_count(tmr_count),
      .period_restart(chan_period_restart[c]),
      .duty_count(chan_duty_count[c*TW +: TW])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_req_wait;
    req && avs_waitrequest;
  endsequence

  sequence s_req_done;
    req && !avs_waitrequest;
  endsequence

  property p_one_wait;
    @(posedge clk) disable iff (!rst_b)
      s_req_wait ##1 req |-> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not after one wait");

  property p_lo_write;
    @(posedge clk) disable iff (!rst_b)
      (s_req_done and (avs_write && hit_lo && avs_byteenable[0]))
        |=> sel_lo_q == $past(avs_writedata[7:0]);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low write lost");

  property p_hi_write;
    @(posedge clk) disable iff (!rst_b)
      (s_req_done and (avs_write && hit_hi && avs_byteenable[0]))
        |=> sel_hi_q == $past(avs_writedata[1:0]);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("high write lost");

  property p_hi_zero;
    @(posedge clk) disable iff (!rst_b)
      (s_req_done and (avs_read && hit_hi)) |-> avs_readdata[31:2] == 30'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("unimplemented bits set");

  property p_lo_read;
    @(posedge clk) disable iff (!rst_b)
      (s_req_done and (avs_read && hit_lo)) |-> avs_readdata == {24'h000000, sel_lo_q};
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("low read mismatch");

  property p_reset_zero;
    @(posedge clk) disable iff (!rst_b)
      $rose(rst_b) |-> (sel_lo_q == 8'h00 && sel_hi_q == 2'h0 && chan_period_restart == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("selectors not cleared");

  property p_ch2_t4;
    @(posedge clk) disable iff (!rst_b)
      (chan_pwm_mode[1] && sel_lo_q[3:2] == PTS_SEL_T4)
        |=> chan_period_restart[1] == $past(tmr_period_match[1]);
  endproperty
  a_ch2_t4: assert property (p_ch2_t4) else $error("channel 2 not on timer 4");

  property p_idle_chan;
    @(posedge clk) disable iff (!rst_b)
      !chan_pwm_mode[4] |=> !chan_period_restart[4];
  endproperty
  a_idle_chan: assert property (p_idle_chan) else $error("channel 5 routed idle");

endmodule // pts_timebase_select

`default_nettype wire

// *** pts_timebase_select_tb.sv ***
// Testbench for the PWM timebase selector: register access and routing.
// Assumes the Avalon-MM slave answers after one wait cycle, one clock domain.
`default_nettype none

module pts_timebase_select_tb
  import pts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] chan_pwm_mode = 5'h1f;
  logic [2:0] match = 3'h5; // Timer 4 match low sets code 01 apart from codes 00 and 10
  logic [23:0] tcnt = 24'h664422;
  logic [4:0] chan_period_restart;
  logic [39:0] chan_duty_count;
  logic [31:0] rd;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  pts_timebase_select #(.TW(8)) u_dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chan_pwm_mode(chan_pwm_mode),
    .tmr_period_match(match), .tmr_count(tcnt),
    .chan_period_restart(chan_period_restart), .chan_duty_count(chan_duty_count));

  // 20 MHz clock
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle; an edge passes first so a release never meets a new request
  // No local limit: only the hang guard ends a wait for the answer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0, 4'hf, rd);
    chk(rd, {32'h0, exp});
  endtask

  // Program both selectors, then compare every channel against its timer
  task automatic route(input logic [7:0] lo, input logic [1:0] hi);
    logic [1:0] c;
    reg_wr(PTS_OFS_SEL_LO, {24'h0, lo}, 4'hf);
    reg_wr(PTS_OFS_SEL_HI, {30'h0, hi}, 4'hf);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      c = (i < 4) ? lo[2*i +: 2] : hi;
      chk(chan_duty_count[8*i +: 8], (c == 2'h3) ? 8'h00 : tcnt[8*c +: 8]);
      chk(chan_period_restart[i], (c == 2'h3) ? 1'b0 : match[c]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(PTS_OFS_SEL_LO, 8'h00);
    reg_rd(PTS_OFS_SEL_HI, 8'h00);
    $display("test reset values done");
    reg_wr(PTS_OFS_SEL_HI, 32'hffff_fffe, 4'hf);
    reg_rd(PTS_OFS_SEL_HI, 8'h02);
    reg_wr(4'h8, 32'h0000_00aa, 4'hf);
    reg_rd(4'h8, 8'h00);
    reg_rd(PTS_OFS_SEL_LO, 8'h00);
    reg_wr(PTS_OFS_SEL_LO, 32'h0000_009a, 4'he);
    reg_rd(PTS_OFS_SEL_LO, 8'h00);
    reg_wr(PTS_OFS_SEL_LO, 32'h0000_009a, 4'hf);
    reg_rd(PTS_OFS_SEL_LO, 8'h9a);
    $display("test register access done");
    // Software never writes the reserved code, so only legal mixes are used
    for (int k = 0; k < 3; k++)
      route({4{k[1:0]}}, k[1:0]);
    route(8'h86, 2'h2);
    route(8'h24, 2'h1);
    $display("test routing done");
    chan_pwm_mode <= 5'h00;
    repeat (2) @(posedge clk);
    chk(chan_duty_count, 40'h0);
    chk(chan_period_restart, 40'h0);
    $display("test pwm mode off done");
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    reg_rd(PTS_OFS_SEL_LO, 8'h00);
    reg_rd(PTS_OFS_SEL_HI, 8'h00);
    $display("test second reset done");
    close_out();
  end

endmodule // pts_timebase_select_tb

`default_nettype wire
